// file: seq_exec.sv
// sequence instruction executor with its fixed side-effect registers
`timescale 1ns/10ps
`include "seq_exec_regs.svh"
module seq_exec (
  input wire logic mclk,
  input wire logic rst,
  input wire seq_exec_pkg::instr_s instr,
  input wire logic instr_valid,
  output logic instr_ready,
  output logic [7:0] skip_count,
  output logic skip_valid,
  input wire logic [31:0] conditions,
  input wire logic [27:0] trigger_mask_in,
  input wire logic wdog_sequence_done,
  output logic [27:0] trigger_mask,
  output logic shared_delay,
  output logic reset_output_n,
  output logic [4:0] buck_reset,
  output logic internal_regulator_disable,
  output logic [7:0] long_window_duration,
  output logic long_window_rearm,
  output logic first_startup_complete,
  output logic [7:0] recovery_count,
  output logic force_drive_low,
  output logic serial_low_power_enable,
  output logic input_supply_monitor_enable,
  output logic analog_mux_out_enable,
  output logic clock_monitor_enable,
  output logic low_power_mode_enable,
  input wire logic [10:0] rd_addr,
  output logic [7:0] rd_data,
  output seq_exec_pkg::reg_wr_s ext_wr,
  input wire logic [7:0] ext_rd_data
);
  import seq_exec_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    exec_state_e st;
    instr_s cur;
    logic [15:0] step_cnt;
    logic [7:0] delay_left;
    logic shared;
    logic [7:0] skip;
    logic skip_v;
    logic [7:0] ldo_r;
    logic [7:0] misc_r;
    logic [7:0] enable_drive_cmd_r;
    logic [7:0] buck_r;
    logic [7:0] rtc_r;
    logic [7:0] lwin_r;
    logic [7:0] wdmode_r;
    logic [7:0] vmon_r;
    logic [7:0] rcnt_r;
    logic [7:0] sreg0;
    logic [7:0] sreg1;
    logic [7:0] sreg2;
    logic [7:0] sreg3;
    logic [27:0] trig_r;
    logic rearm_r;
    reg_wr_s ext;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  // ==========================================================
  // helpers
  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] d,
                                       input logic [7:0] m);
    merge = (old & m) | (d & ~m);
  endfunction : merge

  // limitation: unmapped reads come from ext_rd_data, which follows
  // rd_addr, so masked writes there merge with that word
  function automatic logic [7:0] reg_read(input state_s s,
                                          input logic [10:0] a,
                                          input logic [7:0] ext_d);
    unique case (a)
      `ADDR_INTERNAL_LDO_CONTROL: reg_read = s.ldo_r;
      `ADDR_MISC_CONTROL: reg_read = s.misc_r;
      `ADDR_ENABLE_DRIVE_STATUS: reg_read = s.enable_drive_cmd_r;
      `ADDR_BUCK_RESET_CONTROL: reg_read = s.buck_r;
      `ADDR_RECOVERY_COUNT_INCREMENT: reg_read = 8'h00;
      `ADDR_RTC_CONTROL_TWO: reg_read = s.rtc_r;
      `ADDR_WATCHDOG_LONG_WINDOW_CONFIG: reg_read = s.lwin_r;
      `ADDR_WATCHDOG_MODE_CONTROL: reg_read = s.wdmode_r;
      `ADDR_INPUT_SUPPLY_MONITOR: reg_read = s.vmon_r;
      default: reg_read = ext_d;
    endcase
  endfunction : reg_read

  logic [7:0] sreg_sel;
  logic cond_true;
  logic [10:0] wa;
  logic [7:0] wd;
  logic [7:0] wm;
  logic wen;
  logic full_wr;
  logic [7:0] cur_val;
  logic [7:0] nv;

  // ==========================================================
  // execution
  always_comb begin
    s_nxt = s_r;
    s_nxt.skip_v = 1'b0;
    s_nxt.shared = 1'b0;
    s_nxt.ext = '0;
    s_nxt.ldo_r[0] = 1'b0;
    s_nxt.wdmode_r[0] = 1'b0;
    wen = 1'b0;
    full_wr = 1'b0;
    wa = s_r.cur.addr;
    wd = s_r.cur.data;
    wm = s_r.cur.mask;
    cur_val = 8'h00;
    nv = 8'h00;
    unique case (s_r.cur.sreg)
      2'd0: sreg_sel = s_r.sreg0;
      2'd1: sreg_sel = s_r.sreg1;
      2'd2: sreg_sel = s_r.sreg2;
      default: sreg_sel = s_r.sreg3;
    endcase
    cond_true = conditions[s_r.cur.cond_sel] == s_r.cur.cond_pol;
    // clear first so a same-cycle rearm below wins
    if (wdog_sequence_done) begin
      s_nxt.rearm_r = 1'b0;
    end
    unique case (s_r.st)
      ST_IDLE: begin
        if (instr_valid) begin
          s_nxt.cur = instr;
          s_nxt.st = ST_EXEC;
        end
      end
      ST_EXEC: begin
        s_nxt.st = ST_IDLE;
        unique case (s_r.cur.opcode)
          `OP_MASKED_IMMEDIATE_WRITE: wen = 1'b1;
          `OP_FULL_IMMEDIATE_WRITE: begin
            wen = 1'b1;
            full_wr = 1'b1;
          end
          `OP_MASKED_SCRATCH_WRITE: begin
            wen = 1'b1;
            wd = sreg_sel;
          end
          `OP_SCRATCH_LOAD_FROM_REG,
          `OP_SCRATCH_IMMEDIATE_LOAD: begin
            nv = (s_r.cur.opcode == `OP_SCRATCH_LOAD_FROM_REG) ?
                 reg_read(s_r, s_r.cur.addr, ext_rd_data) :
                 s_r.cur.data;
            unique case (s_r.cur.sreg)
              2'd0: s_nxt.sreg0 = nv;
              2'd1: s_nxt.sreg1 = nv;
              2'd2: s_nxt.sreg2 = nv;
              default: s_nxt.sreg3 = nv;
            endcase
          end
          `OP_IMMEDIATE_DELAY: begin
            s_nxt.delay_left = s_r.cur.delay;
            s_nxt.step_cnt = `STEP_CYCLES;
            s_nxt.shared = 1'b1;
            s_nxt.st = ST_DELAY;
          end
          `OP_SCRATCH_SOURCED_DELAY: begin
            // local only: never flagged to other devices
            s_nxt.delay_left = sreg_sel;
            s_nxt.step_cnt = `STEP_CYCLES;
            s_nxt.st = ST_DELAY;
          end
          `OP_TRIGGER_MASK_SET: s_nxt.trig_r = trigger_mask_in;
          `OP_WAIT: begin
            if (cond_true) begin
              s_nxt.st = ST_IDLE;
            // only the low six bits count as timeout steps
            end else if (s_r.cur.delay[5:0] != 6'h00) begin
              s_nxt.delay_left = {2'b00, s_r.cur.delay[5:0]};
              s_nxt.step_cnt = `STEP_CYCLES;
              s_nxt.st = ST_WAIT;
            end else begin
              s_nxt.skip = (s_r.cur.skip == 8'h00) ? 8'h01 : s_r.cur.skip;
              s_nxt.skip_v = 1'b1;
            end
          end
          `OP_JUMP: begin
            s_nxt.skip = (s_r.cur.skip == 8'h00) ? 8'h01 : s_r.cur.skip;
            s_nxt.skip_v = 1'b1;
          end
          `OP_RESET_OUTPUT: begin
            // data bit 1 chooses high/low, bit 0 marks unchanged
            wa = `ADDR_MISC_CONTROL;
            wd = {7'h00, s_r.cur.data[1]} << `BIT_RESET_OUTPUT;
            wm = ~(8'h01 << `BIT_RESET_OUTPUT);
            // unchanged: no write, the exec cycle alone is the delay
            wen = ~s_r.cur.data[0];
          end
          `OP_BUCKS_RESET: begin
            wa = `ADDR_BUCK_RESET_CONTROL;
            wd = {3'b000, s_r.cur.data[4:0]};
            wm = `MASK_BUCKS;
            wen = 1'b1;
          end
          `OP_LOW_POWER_STANDBY: begin
            wa = `ADDR_INTERNAL_LDO_CONTROL;
            wd = `DATA_LOW_POWER_STANDBY;
            wm = `MASK_LOW_POWER_STANDBY;
            wen = 1'b1;
          end
          `OP_SET_LONG_WINDOW: begin
            wa = `ADDR_WATCHDOG_LONG_WINDOW_CONFIG;
            wm = `MASK_NONE;
            wen = 1'b1;
          end
          `OP_RETURN_LONG_WINDOW: begin
            wa = `ADDR_WATCHDOG_MODE_CONTROL;
            wd = `DATA_RETURN_LONG_WINDOW;
            wm = `MASK_RETURN_LONG_WINDOW;
            wen = 1'b1;
          end
          `OP_FIRST_STARTUP: begin
            wa = `ADDR_RTC_CONTROL_TWO;
            wd = `DATA_FIRST_STARTUP;
            wm = `MASK_FIRST_STARTUP;
            wen = 1'b1;
          end
          `OP_RECOVERY_INCREMENT: begin
            wa = `ADDR_RECOVERY_COUNT_INCREMENT;
            wd = `DATA_RECOVERY_INCREMENT;
            wm = `MASK_RECOVERY_INCREMENT;
            wen = 1'b1;
          end
          `OP_POWER_UP: begin
            s_nxt.enable_drive_cmd_r[`BIT_SERIAL_LOW_POWER] = 1'b0;
            s_nxt.vmon_r[`BIT_INPUT_SUPPLY_MONITOR] = s_r.cur.data[0];
            s_nxt.misc_r[`BIT_ANALOG_MUX_OUT] = s_r.cur.data[1];
            s_nxt.misc_r[`BIT_CLOCK_MONITOR] = s_r.cur.data[2];
            s_nxt.misc_r[`BIT_LOW_POWER_MODE] = 1'b0;
          end
          `OP_POWER_DOWN: begin
            s_nxt.enable_drive_cmd_r[`BIT_SERIAL_LOW_POWER] = 1'b1;
            s_nxt.vmon_r[`BIT_INPUT_SUPPLY_MONITOR] = s_r.cur.data[0];
            s_nxt.misc_r[`BIT_ANALOG_MUX_OUT] = s_r.cur.data[1];
            s_nxt.misc_r[`BIT_LOW_POWER_MODE] = 1'b1;
          end
          `OP_ENABLE_DRIVE: begin
            wa = `ADDR_ENABLE_DRIVE_STATUS;
            wd = s_r.cur.data[0] ? `DATA_FORCE_DRIVE_LOW : 8'h00;
            wm = `MASK_FORCE_DRIVE_LOW;
            wen = 1'b1;
          end
          default: s_nxt.st = ST_IDLE;
        endcase
        if (wen) begin
          if (full_wr) begin
            wm = `MASK_NONE;
          end
          cur_val = reg_read(s_r, wa, ext_rd_data);
          nv = merge(cur_val, wd, wm);
          unique case (wa)
            `ADDR_INTERNAL_LDO_CONTROL: s_nxt.ldo_r = nv;
            `ADDR_MISC_CONTROL: s_nxt.misc_r = nv;
            `ADDR_ENABLE_DRIVE_STATUS: s_nxt.enable_drive_cmd_r = nv;
            `ADDR_BUCK_RESET_CONTROL: s_nxt.buck_r = nv;
            `ADDR_RECOVERY_COUNT_INCREMENT: begin
              if (nv[0]) begin
                s_nxt.rcnt_r = s_r.rcnt_r + 8'h01;
              end
            end
            `ADDR_RTC_CONTROL_TWO: s_nxt.rtc_r = nv;
            `ADDR_WATCHDOG_LONG_WINDOW_CONFIG: s_nxt.lwin_r = nv;
            `ADDR_WATCHDOG_MODE_CONTROL: begin
              s_nxt.wdmode_r = nv;
              if (nv[0]) begin
                s_nxt.rearm_r = 1'b1;
              end
            end
            `ADDR_INPUT_SUPPLY_MONITOR: s_nxt.vmon_r = nv;
            // one-cycle strobe; the far side latches it
            default: s_nxt.ext = '{valid: 1'b1, addr: wa, data: nv};
          endcase
        end
      end
      // a step lasts STEP_CYCLES clocks, the block ends on zero
      ST_DELAY, ST_WAIT: begin
        // condition sampled each cycle so an early true is not missed
        if (s_r.st == ST_WAIT && cond_true) begin
          s_nxt.st = ST_IDLE;
        end else if (s_r.delay_left == 8'h00) begin
          s_nxt.st = ST_IDLE;
          if (s_r.st == ST_WAIT) begin
            s_nxt.skip = (s_r.cur.skip == 8'h00) ? 8'h01 : s_r.cur.skip;
            s_nxt.skip_v = 1'b1;
          end
        end else if (s_r.step_cnt <= 16'd1) begin
          s_nxt.step_cnt = `STEP_CYCLES;
          s_nxt.delay_left = s_r.delay_left - 8'h01;
        end else begin
          s_nxt.step_cnt = s_r.step_cnt - 16'd1;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '0;
      // reset output comes out of reset released high
      s_r.ldo_r <= `RESET_REG;
      s_r.misc_r <= `RESET_MISC_CONTROL;
      s_r.enable_drive_cmd_r <= `RESET_REG;
      s_r.buck_r <= `RESET_REG;
      s_r.rtc_r <= `RESET_REG;
      s_r.lwin_r <= `RESET_REG;
      s_r.wdmode_r <= `RESET_REG;
      s_r.vmon_r <= `RESET_REG;
      s_r.rcnt_r <= `RESET_REG;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign instr_ready = s_r.st == ST_IDLE;
  assign skip_count = s_r.skip;
  assign skip_valid = s_r.skip_v;
  assign trigger_mask = s_r.trig_r;
  assign shared_delay = s_r.shared;
  assign reset_output_n = s_r.misc_r[`BIT_RESET_OUTPUT];
  assign buck_reset = s_r.buck_r[4:0];
  assign internal_regulator_disable = s_r.ldo_r[0];
  assign long_window_duration = s_r.lwin_r;
  assign long_window_rearm = s_r.rearm_r;
  assign first_startup_complete = s_r.rtc_r[7];
  assign recovery_count = s_r.rcnt_r;
  assign force_drive_low = s_r.enable_drive_cmd_r[`BIT_FORCE_DRIVE_LOW];
  assign serial_low_power_enable = s_r.enable_drive_cmd_r[`BIT_SERIAL_LOW_POWER];
  assign input_supply_monitor_enable =
    s_r.vmon_r[`BIT_INPUT_SUPPLY_MONITOR];
  assign analog_mux_out_enable = s_r.misc_r[`BIT_ANALOG_MUX_OUT];
  assign clock_monitor_enable = s_r.misc_r[`BIT_CLOCK_MONITOR];
  assign low_power_mode_enable = s_r.misc_r[`BIT_LOW_POWER_MODE];
  assign rd_data = reg_read(s_r, rd_addr, ext_rd_data);
  assign ext_wr = s_r.ext;
endmodule : seq_exec

// file: seq_exec_pkg.sv
// types shared by the sequencer executor and its environment
package seq_exec_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DELAY, ST_WAIT} exec_state_e;
  typedef struct packed {
    logic [4:0] opcode;
    logic [10:0] addr;
    logic [7:0] data;
    logic [7:0] mask;
    logic [1:0] sreg;
    logic [7:0] delay;
    logic [7:0] skip;
    logic [4:0] cond_sel;
    logic cond_pol;
  } instr_s;
  typedef struct packed {
    logic valid;
    logic [10:0] addr;
    logic [7:0] data;
  } reg_wr_s;
endpackage : seq_exec_pkg

// file: seq_exec_props.sv
// port assertions for the sequencer executor
`timescale 1ns/10ps
`include "seq_exec_regs.svh"
module seq_exec_props (
  input wire logic mclk,
  input wire logic rst,
  input wire seq_exec_pkg::instr_s instr,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic [7:0] skip_count,
  input wire logic skip_valid,
  input wire logic [27:0] trigger_mask_in,
  input wire logic [27:0] trigger_mask,
  input wire logic shared_delay,
  input wire logic internal_regulator_disable,
  input wire logic first_startup_complete,
  input wire logic [7:0] recovery_count
);
  import seq_exec_pkg::*;
  // ==================================================
  // sequences
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence any_take_s;
    instr_valid && instr_ready;
  endsequence
  sequence take_s(logic [4:0] op);
    instr_valid && instr_ready && instr.opcode == op;
  endsequence
  // ==================================================
  // properties
  chk_busy_after_take: assert property (any_take_s |=> !instr_ready)
    else $error("ready stayed high after a take");
  chk_skip_forward: assert property (skip_valid |-> skip_count != 8'h00)
    else $error("branch with zero skip");
  chk_jump_skips: assert property (take_s(`OP_JUMP) |->
    ##2 skip_valid && skip_count == $past(instr.skip, 2))
    else $error("jump did not skip forward");
  chk_ldo_self_clear: assert property (
    $rose(internal_regulator_disable) |=> !internal_regulator_disable)
    else $error("regulator disable bit held");
  chk_standby_pulse: assert property (
    take_s(`OP_LOW_POWER_STANDBY) |-> ##2 internal_regulator_disable)
    else $error("standby did not set disable bit");
  chk_recovery_step: assert property ($changed(recovery_count) |->
    recovery_count == 8'($past(recovery_count) + 8'h01))
    else $error("recovery count moved by other than one");
  chk_startup_flag: assert property (
    take_s(`OP_FIRST_STARTUP) |-> ##2 first_startup_complete)
    else $error("first startup flag not set");
  chk_trig_capture: assert property (take_s(`OP_TRIGGER_MASK_SET) |->
    ##2 trigger_mask == $past(trigger_mask_in, 2))
    else $error("trigger mask not captured");
  chk_shared_pulse: assert property (
    take_s(`OP_IMMEDIATE_DELAY) |-> ##2 shared_delay)
    else $error("immediate delay not shared");
  chk_local_delay: assert property (
    take_s(`OP_SCRATCH_SOURCED_DELAY) |-> ##1 !shared_delay [*4])
    else $error("scratch delay leaked to others");
endmodule : seq_exec_props
bind seq_exec seq_exec_props u_props (.mclk(mclk), .rst(rst), .instr(instr),
  .instr_valid(instr_valid), .instr_ready(instr_ready),
  .skip_count(skip_count), .skip_valid(skip_valid),
  .trigger_mask_in(trigger_mask_in), .trigger_mask(trigger_mask),
  .shared_delay(shared_delay),
  .internal_regulator_disable(internal_regulator_disable),
  .first_startup_complete(first_startup_complete),
  .recovery_count(recovery_count));

// file: seq_exec_regs.svh
// register addresses, field positions, opcodes and constants of the executor
`ifndef SEQ_EXEC_REGS_SVH
`define SEQ_EXEC_REGS_SVH
`define ADDR_INTERNAL_LDO_CONTROL 11'h021
`define ADDR_MISC_CONTROL 11'h081
`define ADDR_ENABLE_DRIVE_STATUS 11'h082
`define ADDR_BUCK_RESET_CONTROL 11'h087
`define ADDR_RECOVERY_COUNT_INCREMENT 11'h0a5
`define ADDR_RTC_CONTROL_TWO 11'h0c3
`define ADDR_WATCHDOG_LONG_WINDOW_CONFIG 11'h405
`define ADDR_WATCHDOG_MODE_CONTROL 11'h406
`define ADDR_INPUT_SUPPLY_MONITOR 11'h02b
`define BIT_RESET_OUTPUT 0
`define BIT_CLOCK_MONITOR 1
`define BIT_ANALOG_MUX_OUT 2
`define BIT_LOW_POWER_MODE 3
`define BIT_SERIAL_LOW_POWER 4
`define BIT_FORCE_DRIVE_LOW 3
`define BIT_INPUT_SUPPLY_MONITOR 0
`define MASK_BUCKS 8'he0
`define DATA_LOW_POWER_STANDBY 8'h01
`define MASK_LOW_POWER_STANDBY 8'hfe
`define DATA_FIRST_STARTUP 8'h80
`define MASK_FIRST_STARTUP 8'h7f
`define DATA_RETURN_LONG_WINDOW 8'h01
`define MASK_RETURN_LONG_WINDOW 8'hfe
`define DATA_RECOVERY_INCREMENT 8'h01
`define MASK_RECOVERY_INCREMENT 8'hfe
`define DATA_FORCE_DRIVE_LOW 8'h08
`define MASK_FORCE_DRIVE_LOW 8'hf7
`define MASK_NONE 8'h00
`define RESET_REG 8'h00
`define RESET_MISC_CONTROL 8'h01
`define STEP_TIME_NS 25600
`define CLK_PERIOD_NS 100
`define STEP_CYCLES 16'((`STEP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OP_MASKED_IMMEDIATE_WRITE 5'h00
`define OP_FULL_IMMEDIATE_WRITE 5'h01
`define OP_MASKED_SCRATCH_WRITE 5'h02
`define OP_SCRATCH_LOAD_FROM_REG 5'h03
`define OP_SCRATCH_IMMEDIATE_LOAD 5'h04
`define OP_SCRATCH_SOURCED_DELAY 5'h05
`define OP_IMMEDIATE_DELAY 5'h06
`define OP_TRIGGER_MASK_SET 5'h07
`define OP_WAIT 5'h08
`define OP_JUMP 5'h09
`define OP_RESET_OUTPUT 5'h0a
`define OP_BUCKS_RESET 5'h0b
`define OP_LOW_POWER_STANDBY 5'h0c
`define OP_SET_LONG_WINDOW 5'h0d
`define OP_RETURN_LONG_WINDOW 5'h0e
`define OP_FIRST_STARTUP 5'h0f
`define OP_RECOVERY_INCREMENT 5'h10
`define OP_POWER_UP 5'h11
`define OP_POWER_DOWN 5'h12
`define OP_ENABLE_DRIVE 5'h13
`endif

// file: sibling_model.sv
// far side model: sibling devices and the watchdog host
`timescale 1ns/10ps
module sibling_model (
  input wire logic mclk,
  input wire logic rst,
  input wire seq_exec_pkg::reg_wr_s ext_wr,
  input wire logic [10:0] rd_addr,
  input wire logic shared_delay,
  input wire logic long_window_rearm,
  output logic [7:0] ext_rd_data,
  output logic wdog_sequence_done,
  output logic [7:0] delays_seen
);
  import seq_exec_pkg::*;
  logic [7:0] mem [8];
  logic [3:0] wd_cnt;
  // watchdog sequence ends some cycles after rearm request
  assign wdog_sequence_done = (wd_cnt == 4'h8);
  assign ext_rd_data = mem[rd_addr[2:0]];
  always_ff @(posedge mclk) begin
    if (rst) begin
      delays_seen <= 8'h00;
      wd_cnt <= 4'h0;
      for (int i = 0; i < 8; i++) mem[i] <= 8'ha5 ^ 8'(i);
    end else begin
      // siblings delay on every shared step delay
      if (shared_delay) delays_seen <= delays_seen + 8'h01;
      wd_cnt <= long_window_rearm ? wd_cnt + 4'h1 : 4'h0;
      if (ext_wr.valid) mem[ext_wr.addr[2:0]] <= ext_wr.data;
    end
  end
endmodule : sibling_model

// file: testbench.sv
// self-checking testbench for the sequencer executor
`timescale 1ns/10ps
`include "seq_exec_regs.svh"
`define CK(a, b) \
  begin \
    checked++; \
    if ((a) !== (b)) begin \
      bad_count++; \
      $display("[FAIL] %0t got %0h want %0h", $time, a, b); \
    end \
  end
module testbench;
  import seq_exec_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  instr_s instr = '0;
  logic [31:0] conditions = 32'h00000000;
  logic [27:0] trigger_mask_in = 28'h0000000;
  logic [10:0] rd_addr = 11'h000;
  logic ready, sv, skv, sd, ron, ild, lwr, fsc, fdl, slp, ism, amx, cmn, lpm;
  logic wsd;
  logic [4:0] bkr;
  logic [27:0] tmo;
  logic [7:0] sc, skc, lwd, rcnt, rdd, erd, dseen, d0;
  reg_wr_s ewr;
  int bad_count = 0;
  int checked = 0;
  int n;
  seq_exec DUT (.mclk(mclk), .rst(rst), .instr(instr),
    .instr_valid(instr_valid), .instr_ready(ready), .skip_count(skc),
    .skip_valid(skv), .conditions(conditions),
    .trigger_mask_in(trigger_mask_in), .wdog_sequence_done(wsd),
    .trigger_mask(tmo), .shared_delay(sd), .reset_output_n(ron),
    .buck_reset(bkr), .internal_regulator_disable(ild),
    .long_window_duration(lwd), .long_window_rearm(lwr),
    .first_startup_complete(fsc), .recovery_count(rcnt),
    .force_drive_low(fdl), .serial_low_power_enable(slp),
    .input_supply_monitor_enable(ism), .analog_mux_out_enable(amx),
    .clock_monitor_enable(cmn), .low_power_mode_enable(lpm),
    .rd_addr(rd_addr), .rd_data(rdd), .ext_wr(ewr), .ext_rd_data(erd));
  sibling_model u_sib (.mclk(mclk), .rst(rst), .ext_wr(ewr),
    .rd_addr(rd_addr), .shared_delay(sd), .long_window_rearm(lwr),
    .ext_rd_data(erd), .wdog_sequence_done(wsd), .delays_seen(dseen));
  // ==================================================
  // shared tasks
  task automatic stop_test();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  // one instruction; valid held over the accepting edge
  task automatic run(input logic [4:0] op, input logic [10:0] a = 11'h000,
      input logic [7:0] d = 8'h00, input logic [7:0] m = 8'h00,
      input logic [1:0] s = 2'd0, input logic [7:0] dl = 8'h00,
      input logic [7:0] k = 8'h00, input logic [4:0] cs = 5'h00,
      input logic cp = 1'b1);
    @(negedge mclk);
    instr = '{op, a, d, m, s, dl, k, cs, cp};
    instr_valid = 1'b1;
    @(negedge mclk);
    instr_valid = 1'b0;
    n = 0;
    while (ready !== 1'b1 && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    sv = skv;
    sc = skc;
    if (n >= 3000) begin
      $display("[FAIL] %0t instruction never finished", $time);
      bad_count++;
      stop_test();
    end
  endtask : run
  task automatic chk_rd(input logic [10:0] a, input logic [7:0] e);
    rd_addr = a;
    #1;
    `CK(rdd, e);
  endtask : chk_rd
  // ==================================================
  // scenarios
  task automatic t_writes();
    run(`OP_FULL_IMMEDIATE_WRITE, 11'h081, 8'h0f);
    `CK({lpm, amx, cmn, ron}, 4'hf);
    run(`OP_MASKED_IMMEDIATE_WRITE, 11'h081, 8'h00, 8'hfd);
    chk_rd(11'h081, 8'h0d);
    `CK(cmn, 1'b0);
    run(`OP_FULL_IMMEDIATE_WRITE, 11'h300, 8'h5a);
    @(negedge mclk);
    chk_rd(11'h300, 8'h5a);
  endtask : t_writes
  task automatic t_scratch();
    run(`OP_BUCKS_RESET, 11'h087, 8'h15, 8'he0);
    `CK(bkr, 5'h15);
    run(`OP_SCRATCH_LOAD_FROM_REG, 11'h087, .s(2'd2));
    run(`OP_MASKED_SCRATCH_WRITE, 11'h081, 8'h00, 8'hf0, 2'd2);
    chk_rd(11'h081, 8'h05);
  endtask : t_scratch
  task automatic t_reset_out();
    run(`OP_RESET_OUTPUT, .d(8'h00));
    `CK(ron, 1'b0);
    run(`OP_RESET_OUTPUT, .d(8'h01));
    `CK({ron, n < 4}, 2'b01);
    run(`OP_RESET_OUTPUT, .d(8'h02));
    `CK(ron, 1'b1);
  endtask : t_reset_out
  task automatic t_fixed();
    run(`OP_LOW_POWER_STANDBY);
    `CK(ild, 1'b1);
    @(negedge mclk);
    chk_rd(11'h021, 8'h00);
    run(`OP_SET_LONG_WINDOW, .d(8'hff));
    `CK(lwd, 8'hff);
    run(`OP_SET_LONG_WINDOW, .d(8'h00));
    `CK(lwd, 8'h00);
    run(`OP_RETURN_LONG_WINDOW);
    `CK(lwr, 1'b1);
    for (int i = 0; i < 30 && lwr; i++) @(negedge mclk);
    `CK(lwr, 1'b0);
    run(`OP_FIRST_STARTUP);
    chk_rd(11'h0c3, 8'h80);
    run(`OP_RECOVERY_INCREMENT);
    run(`OP_RECOVERY_INCREMENT);
    `CK(rcnt, 8'h02);
    run(`OP_ENABLE_DRIVE, .d(8'h01));
    `CK(fdl, 1'b1);
    run(`OP_ENABLE_DRIVE, .d(8'h00));
    `CK(fdl, 1'b0);
  endtask : t_fixed
  task automatic t_composite();
    run(`OP_POWER_DOWN, .d(8'h05));
    `CK({slp, ism, amx, lpm, cmn}, 5'b11010);
    run(`OP_POWER_UP, .d(8'h06));
    `CK({slp, ism, amx, lpm, cmn}, 5'b00101);
  endtask : t_composite
  task automatic t_wait();
    conditions = 32'h80000000;
    run(`OP_WAIT, .k(8'h03), .cs(5'h1f));
    `CK(sv, 1'b0);
    run(`OP_WAIT, .k(8'h03), .cs(5'h1f), .cp(1'b0));
    `CK({sv, sc}, 9'h103);
    conditions = 32'h00000000;
    run(`OP_WAIT, .k(8'h00));
    `CK(sc, 8'h01);
    conditions[0] = 1'b1;
    run(`OP_JUMP, .k(8'h07));
    `CK({sv, sc}, 9'h107);
    conditions[0] = 1'b0;
    run(`OP_WAIT, .dl(8'h01), .k(8'h02));
    `CK({sv, n >= 250}, 2'b11);
    fork
      run(`OP_WAIT, .dl(8'h01), .k(8'h02));
      begin
        repeat (40) @(negedge mclk);
        conditions[0] = 1'b1;
      end
    join
    `CK({sv, n < 100}, 2'b01);
  endtask : t_wait
  task automatic t_delay();
    d0 = dseen;
    run(`OP_IMMEDIATE_DELAY, .dl(8'h02));
    `CK({n >= 500, dseen}, {1'b1, 8'(d0 + 8'h01)});
    run(`OP_SCRATCH_IMMEDIATE_LOAD, .d(8'h01), .s(2'd1));
    run(`OP_SCRATCH_SOURCED_DELAY, .s(2'd1));
    `CK({n >= 250, dseen}, {1'b1, 8'(d0 + 8'h01)});
    trigger_mask_in = 28'h0a5c3e1;
    run(`OP_TRIGGER_MASK_SET);
    `CK(tmo, 28'h0a5c3e1);
  endtask : t_delay
  task automatic t_reset();
    @(negedge mclk);
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    `CK({ron, bkr, ild, lwd, lwr, fsc, rcnt, fdl}, {1'b1, 25'h0});
    `CK({slp, ism, amx, cmn, lpm, ready, skv, sd}, 8'h04);
    `CK(tmo, 28'h0000000);
    run(`OP_RECOVERY_INCREMENT);
    `CK(rcnt, 8'h01);
  endtask : t_reset
  // ==================================================
  // main sequence
  initial begin
    forever #50 mclk = ~mclk;
  end
  initial begin
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    `CK(ron, 1'b1);
    t_writes();
    t_scratch();
    t_reset_out();
    t_fixed();
    t_composite();
    t_wait();
    t_delay();
    t_reset();
    stop_test();
  end
endmodule : testbench
